// ### rtl/drive_ctrl_pkg.sv
// shared constants and types of the drive control special registers
package drive_ctrl_pkg;

   // register index on the program access port
   localparam logic [4:0] IDX_OPER_CTRL = 5'h00;
   localparam logic [4:0] IDX_CTRL_MASK = 5'h01;
   localparam logic [4:0] IDX_ACC_ERR = 5'h02;
   localparam logic [4:0] IDX_DRV_STATUS = 5'h03;
   localparam logic [4:0] IDX_USER_FAULT = 5'h04;
   localparam logic [4:0] IDX_MON_DEC = 5'h05;
   localparam logic [4:0] IDX_MON_ONE = 5'h06;
   localparam logic [4:0] IDX_MON_TWO = 5'h07;
   localparam logic [4:0] IDX_MON_THREE = 5'h08;
   localparam logic [4:0] IDX_RAM_NUM = 5'h09;
   localparam logic [4:0] IDX_RAM_CONT = 5'h0A;
   localparam logic [4:0] IDX_EEP_NUM = 5'h0B;
   localparam logic [4:0] IDX_EEP_CONT = 5'h0C;
   localparam logic [4:0] IDX_RAM_CAL = 5'h0D;
   localparam logic [4:0] IDX_EEP_CAL = 5'h0E;
   localparam logic [4:0] IDX_RAM_DW_LO = 5'h0F;
   localparam logic [4:0] IDX_RAM_DW_HI = 5'h10;
   localparam logic [4:0] IDX_EEP_DW_LO = 5'h11;
   localparam logic [4:0] IDX_EEP_DW_HI = 5'h12;

   localparam int CTRL_BITS = 12;
   localparam int OUTPUT_STOP_BIT = 6;
   localparam logic [15:0] CTRL_MASK_USED = 16'h0FFF;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic [15:0] ERR_OFFSET = 16'h8000;
   localparam logic [15:0] ERR_ALL_ONES = 16'hFFFF;
   localparam logic [15:0] ERR_CLEAR = 16'h0000;
   localparam logic [15:0] USER_FAULT_MIN = 16'h0010;
   localparam logic [15:0] USER_FAULT_MAX = 16'h0014;

   // monitor panel selection codes and decimal field positions
   localparam logic [7:0] MON_SEL_ONE = 8'h28;
   localparam logic [7:0] MON_SEL_TWO = 8'h29;
   localparam logic [7:0] MON_SEL_THREE = 8'h2A;
   localparam int DEC_POS_ONE = 8;
   localparam int DEC_POS_TWO = 10;
   localparam int DEC_POS_THREE = 12;
   localparam logic [15:0] DEC_USED = 16'h3F00;
   localparam int PANEL_SLOTS = 3;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,
      RD_RAM = 2'b01,
      RD_EEP = 2'b10
   } read_state_t;

   typedef struct packed {
      logic req;
      logic eeprom;
      logic [15:0] number;
      logic [15:0] cal_sel;
   } param_read_req_t;

   typedef struct packed {
      logic ack;
      logic error;
      logic double_word;
      logic [31:0] data;
   } param_read_rsp_t;

   typedef struct packed {
      logic visible;
      logic [1:0] decimals;
      logic [15:0] value;
   } panel_view_t;

endpackage

// ### rtl/drive_control_special_registers.sv
// special registers between the sequence program and the drive core
`timescale 1ns/1ps

module drive_control_special_registers
   import drive_ctrl_pkg::*;
(
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic prog_wr_i,
   input wire logic [4:0] prog_idx_i,
   input wire logic [15:0] prog_wdata_i,
   output logic [15:0] prog_rdata_o,
   input wire logic special_register_select_flag_i,
   input wire logic [11:0] per_bit_control_flags_i,
   input wire logic [11:0] terminal_inputs_i,
   input wire logic [11:0] fieldbus_inputs_i,
   input wire logic sequence_start_input_i,
   output logic [11:0] run_command_o,
   output logic sequence_start_o,
   input wire logic [15:0] drive_status_i,
   input wire logic [15:0] program_function_enable_i,
   input wire logic user_fault_clear_i,
   output logic user_fault_alarm_o,
   output logic [15:0] user_fault_code_o,
   input wire logic core_mode_error_i,
   input wire logic core_param_error_i,
   input wire logic [15:0] core_param_number_i,
   input wire logic [7:0] monitor_select_params_i [PANEL_SLOTS],
   output panel_view_t panel_view_o [PANEL_SLOTS],
   input wire logic ram_read_command_i,
   input wire logic eeprom_read_command_i,
   output logic ram_read_done_o,
   output logic eeprom_read_done_o,
   output logic double_word_read_flag_o,
   output param_read_req_t param_read_req_o,
   input wire param_read_rsp_t param_read_rsp_i
);

   logic [15:0] operating_control_word;
   logic [15:0] control_enable_mask;
   logic [15:0] access_error_code;
   logic [15:0] user_fault_trigger;
   logic [15:0] monitor_decimal_select;
   logic [15:0] user_monitor_one;
   logic [15:0] user_monitor_two;
   logic [15:0] user_monitor_three;
   logic [15:0] ram_param_number;
   logic [15:0] ram_param_content;
   logic [15:0] eeprom_param_number;
   logic [15:0] eeprom_param_content;
   logic [15:0] ram_calibration_selector;
   logic [15:0] eeprom_calibration_selector;
   logic [15:0] ram_double_word_low;
   logic [15:0] ram_double_word_high;
   logic [15:0] eeprom_double_word_low;
   logic [15:0] eeprom_double_word_high;

   read_state_t read_state;
   read_state_t next_read_state;
   logic ram_cmd_prev;
   logic eep_cmd_prev;
   logic ram_pending;
   logic eep_pending;

   // register write decode
   wire wr_oper = prog_wr_i && (prog_idx_i == IDX_OPER_CTRL);
   wire wr_mask = prog_wr_i && (prog_idx_i == IDX_CTRL_MASK);
   wire wr_err = prog_wr_i && (prog_idx_i == IDX_ACC_ERR);
   wire wr_fault = prog_wr_i && (prog_idx_i == IDX_USER_FAULT);
   wire wr_dec = prog_wr_i && (prog_idx_i == IDX_MON_DEC);
   wire wr_mon1 = prog_wr_i && (prog_idx_i == IDX_MON_ONE);
   wire wr_mon2 = prog_wr_i && (prog_idx_i == IDX_MON_TWO);
   wire wr_mon3 = prog_wr_i && (prog_idx_i == IDX_MON_THREE);
   wire wr_rnum = prog_wr_i && (prog_idx_i == IDX_RAM_NUM);
   wire wr_rcont = prog_wr_i && (prog_idx_i == IDX_RAM_CONT);
   wire wr_enum = prog_wr_i && (prog_idx_i == IDX_EEP_NUM);
   wire wr_econt = prog_wr_i && (prog_idx_i == IDX_EEP_CONT);
   wire wr_rcal = prog_wr_i && (prog_idx_i == IDX_RAM_CAL);
   wire wr_ecal = prog_wr_i && (prog_idx_i == IDX_EEP_CAL);
   wire wr_rlo = prog_wr_i && (prog_idx_i == IDX_RAM_DW_LO);
   wire wr_rhi = prog_wr_i && (prog_idx_i == IDX_RAM_DW_HI);
   wire wr_elo = prog_wr_i && (prog_idx_i == IDX_EEP_DW_LO);
   wire wr_ehi = prog_wr_i && (prog_idx_i == IDX_EEP_DW_HI);

   // run command selection
   wire [11:0] mask_bits = control_enable_mask[CTRL_BITS-1:0];
   wire [11:0] prog_bits = operating_control_word[CTRL_BITS-1:0]
      | per_bit_control_flags_i;
   wire [11:0] prog_active = special_register_select_flag_i ?
      prog_bits : 12'h000;
   wire [11:0] ext_bits = terminal_inputs_i | fieldbus_inputs_i;
   wire [11:0] stop_keep = 12'h001 << OUTPUT_STOP_BIT;
   // the output-stop terminal stays live so a wired stop is never defeated
   wire [11:0] next_run_command = (mask_bits & prog_active)
      | (~mask_bits & ext_bits)
      | (mask_bits & stop_keep & terminal_inputs_i);

   // user fault decode
   wire fault_in_range = (prog_wdata_i >= USER_FAULT_MIN)
      && (prog_wdata_i <= USER_FAULT_MAX);
   wire fault_enabled =
      (program_function_enable_i != RESET_WORD);
   wire fault_raise = wr_fault && fault_in_range && fault_enabled;

   // parameter read handshake
   wire ram_rise = ram_read_command_i && !ram_cmd_prev;
   wire eep_rise = eeprom_read_command_i && !eep_cmd_prev;
   wire rd_busy = (read_state != RD_IDLE);
   wire rd_ack = rd_busy && param_read_rsp_i.ack;
   wire ram_ack = rd_ack && (read_state == RD_RAM);
   wire eep_ack = rd_ack && (read_state == RD_EEP);
   wire rd_fail = rd_ack && param_read_rsp_i.error;
   wire rd_good = rd_ack && !param_read_rsp_i.error;
   wire start_ram = !rd_busy && ram_pending;
   wire start_eep = !rd_busy && !ram_pending && eep_pending;
   wire [15:0] rd_number = (read_state == RD_EEP) ?
      eeprom_param_number : ram_param_number;
   wire [15:0] rsp_low = param_read_rsp_i.data[15:0];
   wire [15:0] rsp_high = param_read_rsp_i.data[31:16];

   // error code: hardware events win over a program clear in the same cycle
   wire [15:0] next_access_error_code =
      rd_fail ? (rd_number + ERR_OFFSET) :
      core_param_error_i ? (core_param_number_i + ERR_OFFSET) :
      core_mode_error_i ? ERR_ALL_ONES :
      (wr_err && prog_wdata_i == ERR_CLEAR) ? ERR_CLEAR :
      access_error_code;

   always_comb begin
      next_read_state = read_state;
      case (read_state)
         RD_IDLE: begin
            if (start_ram) begin
               next_read_state = RD_RAM;
            end else if (start_eep) begin
               next_read_state = RD_EEP;
            end
         end
         RD_RAM, RD_EEP: begin
            if (param_read_rsp_i.ack) begin
               next_read_state = RD_IDLE;
            end
         end
         default: next_read_state = RD_IDLE;
      endcase
   end

   // read data mux; unmapped index reads as zero
   logic [15:0] next_rdata;
   always_comb begin
      next_rdata = RESET_WORD;
      case (prog_idx_i)
         IDX_OPER_CTRL: next_rdata = operating_control_word;
         IDX_CTRL_MASK: next_rdata = control_enable_mask;
         IDX_ACC_ERR: next_rdata = access_error_code;
         IDX_DRV_STATUS: next_rdata = drive_status_i;
         IDX_USER_FAULT: next_rdata = user_fault_trigger;
         IDX_MON_DEC: next_rdata = monitor_decimal_select;
         IDX_MON_ONE: next_rdata = user_monitor_one;
         IDX_MON_TWO: next_rdata = user_monitor_two;
         IDX_MON_THREE: next_rdata = user_monitor_three;
         IDX_RAM_NUM: next_rdata = ram_param_number;
         IDX_RAM_CONT: next_rdata = ram_param_content;
         IDX_EEP_NUM: next_rdata = eeprom_param_number;
         IDX_EEP_CONT: next_rdata = eeprom_param_content;
         IDX_RAM_CAL: next_rdata = ram_calibration_selector;
         IDX_EEP_CAL: next_rdata = eeprom_calibration_selector;
         IDX_RAM_DW_LO: next_rdata = ram_double_word_low;
         IDX_RAM_DW_HI: next_rdata = ram_double_word_high;
         IDX_EEP_DW_LO: next_rdata = eeprom_double_word_low;
         IDX_EEP_DW_HI: next_rdata = eeprom_double_word_high;
         default: next_rdata = RESET_WORD;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         operating_control_word <= RESET_WORD;
         control_enable_mask <= RESET_WORD;
         access_error_code <= RESET_WORD;
         monitor_decimal_select <= RESET_WORD;
         user_monitor_one <= RESET_WORD;
         user_monitor_two <= RESET_WORD;
         user_monitor_three <= RESET_WORD;
      end else begin
         if (wr_oper) operating_control_word <= prog_wdata_i;
         // upper mask bits hold no control, kept at zero
         if (wr_mask) begin
            control_enable_mask <= prog_wdata_i & CTRL_MASK_USED;
         end
         access_error_code <= next_access_error_code;
         if (wr_dec) monitor_decimal_select <= prog_wdata_i;
         if (wr_mon1) user_monitor_one <= prog_wdata_i;
         if (wr_mon2) user_monitor_two <= prog_wdata_i;
         if (wr_mon3) user_monitor_three <= prog_wdata_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         user_fault_trigger <= RESET_WORD;
         user_fault_alarm_o <= 1'b0;
         user_fault_code_o <= RESET_WORD;
      end else begin
         if (wr_fault) user_fault_trigger <= prog_wdata_i;
         if (fault_raise) begin
            user_fault_alarm_o <= 1'b1;
            user_fault_code_o <= prog_wdata_i;
         end else if (user_fault_clear_i) begin
            user_fault_alarm_o <= 1'b0;
            user_fault_code_o <= RESET_WORD;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         run_command_o <= 12'h000;
         sequence_start_o <= 1'b0;
         prog_rdata_o <= RESET_WORD;
      end else begin
         run_command_o <= next_run_command;
         sequence_start_o <= sequence_start_input_i;
         prog_rdata_o <= next_rdata;
      end
   end

   // panel view per slot; bits outside the three fields are never looked at
   for (genvar s = 0; s < PANEL_SLOTS; s++) begin : g_panel
      wire sel1 = (monitor_select_params_i[s] == MON_SEL_ONE);
      wire sel2 = (monitor_select_params_i[s] == MON_SEL_TWO);
      wire sel3 = (monitor_select_params_i[s] == MON_SEL_THREE);
      wire [1:0] dec_pick = sel1 ?
         monitor_decimal_select[DEC_POS_ONE +: 2] :
         sel2 ? monitor_decimal_select[DEC_POS_TWO +: 2] :
         sel3 ? monitor_decimal_select[DEC_POS_THREE +: 2] : 2'b00;
      wire [15:0] val_pick = sel1 ? user_monitor_one :
         sel2 ? user_monitor_two :
         sel3 ? user_monitor_three : RESET_WORD;
      always_ff @(posedge mclk_i) begin
         if (srst_i) begin
            panel_view_o[s] <= '0;
         end else begin
            panel_view_o[s].visible <= sel1 | sel2 | sel3;
            panel_view_o[s].decimals <= dec_pick;
            panel_view_o[s].value <= val_pick;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         read_state <= RD_IDLE;
         ram_cmd_prev <= 1'b0;
         eep_cmd_prev <= 1'b0;
         ram_pending <= 1'b0;
         eep_pending <= 1'b0;
         ram_read_done_o <= 1'b0;
         eeprom_read_done_o <= 1'b0;
         double_word_read_flag_o <= 1'b0;
         param_read_req_o <= '0;
      end else begin
         read_state <= next_read_state;
         ram_cmd_prev <= ram_read_command_i;
         eep_cmd_prev <= eeprom_read_command_i;
         // a raised edge waits while the other channel is served
         if (ram_rise) begin
            ram_pending <= 1'b1;
         end else if (start_ram) begin
            ram_pending <= 1'b0;
         end
         if (eep_rise) begin
            eep_pending <= 1'b1;
         end else if (start_eep) begin
            eep_pending <= 1'b0;
         end
         // done set wins over the clear by a dropped command
         if (ram_ack) begin
            ram_read_done_o <= 1'b1;
         end else if (!ram_read_command_i || ram_rise) begin
            ram_read_done_o <= 1'b0;
         end
         if (eep_ack) begin
            eeprom_read_done_o <= 1'b1;
         end else if (!eeprom_read_command_i || eep_rise) begin
            eeprom_read_done_o <= 1'b0;
         end
         if (rd_good) begin
            double_word_read_flag_o <=
               param_read_rsp_i.double_word;
         end else if (start_ram || start_eep) begin
            double_word_read_flag_o <= 1'b0;
         end
         param_read_req_o.req <= start_ram || start_eep;
         if (start_ram) begin
            param_read_req_o.eeprom <= 1'b0;
            param_read_req_o.number <= ram_param_number;
            param_read_req_o.cal_sel <= ram_calibration_selector;
         end else if (start_eep) begin
            param_read_req_o.eeprom <= 1'b1;
            param_read_req_o.number <= eeprom_param_number;
            param_read_req_o.cal_sel <=
               eeprom_calibration_selector;
         end
      end
   end

   // content registers: a good read overwrites any program write
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         ram_param_number <= RESET_WORD;
         ram_param_content <= RESET_WORD;
         eeprom_param_number <= RESET_WORD;
         eeprom_param_content <= RESET_WORD;
         ram_calibration_selector <= RESET_WORD;
         eeprom_calibration_selector <= RESET_WORD;
         ram_double_word_low <= RESET_WORD;
         ram_double_word_high <= RESET_WORD;
         eeprom_double_word_low <= RESET_WORD;
         eeprom_double_word_high <= RESET_WORD;
      end else begin
         if (wr_rnum) ram_param_number <= prog_wdata_i;
         if (wr_enum) eeprom_param_number <= prog_wdata_i;
         if (wr_rcal) ram_calibration_selector <= prog_wdata_i;
         if (wr_ecal) eeprom_calibration_selector <= prog_wdata_i;
         if (rd_good && ram_ack && !param_read_rsp_i.double_word) begin
            ram_param_content <= rsp_low;
         end else if (wr_rcont) begin
            ram_param_content <= prog_wdata_i;
         end
         if (rd_good && eep_ack && !param_read_rsp_i.double_word) begin
            eeprom_param_content <= rsp_low;
         end else if (wr_econt) begin
            eeprom_param_content <= prog_wdata_i;
         end
         if (rd_good && ram_ack && param_read_rsp_i.double_word) begin
            ram_double_word_low <= rsp_low;
            ram_double_word_high <= rsp_high;
         end else begin
            if (wr_rlo) ram_double_word_low <= prog_wdata_i;
            if (wr_rhi) ram_double_word_high <= prog_wdata_i;
         end
         if (rd_good && eep_ack && param_read_rsp_i.double_word) begin
            eeprom_double_word_low <= rsp_low;
            eeprom_double_word_high <= rsp_high;
         end else begin
            if (wr_elo) eeprom_double_word_low <= prog_wdata_i;
            if (wr_ehi) eeprom_double_word_high <= prog_wdata_i;
         end
      end
   end

endmodule // drive_control_special_registers

// ### tb/drive_ctrl_asserts.sv
// concurrent checks on the drive control special register ports
`timescale 1ns/1ps
module drive_ctrl_asserts
   import drive_ctrl_pkg::*;
(
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic prog_wr_i,
   input wire logic [4:0] prog_idx_i,
   input wire logic [15:0] prog_wdata_i,
   input wire logic [15:0] prog_rdata_o,
   input wire logic [11:0] terminal_inputs_i,
   input wire logic [11:0] run_command_o,
   input wire logic [15:0] drive_status_i,
   input wire logic [15:0] program_function_enable_i,
   input wire logic user_fault_alarm_o,
   input wire logic [15:0] user_fault_code_o,
   input wire logic core_mode_error_i,
   input wire logic core_param_error_i,
   input wire logic [15:0] core_param_number_i,
   input wire logic ram_read_command_i,
   input wire logic ram_read_done_o,
   input wire logic double_word_read_flag_o,
   input wire param_read_req_t param_read_req_o,
   input wire param_read_rsp_t param_read_rsp_i
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   logic ack_d;
   // a read error may land a cycle late, so both ack cycles are excluded
   always_ff @(posedge mclk_i) ack_d <= param_read_rsp_i.ack;
   wire no_rd = !param_read_rsp_i.ack && !ack_d;
   wire quiet = no_rd && !prog_wr_i && !core_mode_error_i
      && !core_param_error_i;
   wire fault_wr = prog_wr_i && prog_idx_i == IDX_USER_FAULT;
   wire fault_ok = prog_wdata_i >= USER_FAULT_MIN &&
      prog_wdata_i <= USER_FAULT_MAX && program_function_enable_i != 16'h0000;
   sequence mode_err_s;
      core_mode_error_i && !core_param_error_i && no_rd
         ##1 prog_idx_i == IDX_ACC_ERR;
   endsequence
   sequence param_err_s;
      core_param_error_i && no_rd ##1 prog_idx_i == IDX_ACC_ERR;
   endsequence
   AST_STOP_TERM:
      assert property (terminal_inputs_i[OUTPUT_STOP_BIT] |=>
         run_command_o[OUTPUT_STOP_BIT]) else $error("stop input lost");
   AST_FAULT_RAISE:
      assert property (fault_wr && fault_ok |=> user_fault_alarm_o &&
         user_fault_code_o == $past(prog_wdata_i)) else $error("no alarm");
   AST_FAULT_IGNORE:
      assert property (fault_wr && !fault_ok && !user_fault_alarm_o |=>
         !user_fault_alarm_o) else $error("alarm from bad write");
   AST_ERR_MODE:
      assert property (mode_err_s |=> prog_rdata_o == ERR_ALL_ONES)
         else $error("mode error code wrong");
   AST_ERR_PARAM:
      assert property (param_err_s |=>
         prog_rdata_o == $past(core_param_number_i, 2) + ERR_OFFSET)
         else $error("param error code wrong");
   AST_ERR_HOLD:
      assert property ((quiet && prog_idx_i == IDX_ACC_ERR)[*3] |=>
         $stable(prog_rdata_o)) else $error("error code not held");
   AST_DONE_DROP:
      assert property (ram_read_done_o && !ram_read_command_i &&
         !param_read_rsp_i.ack |=> !ram_read_done_o) else $error("done stuck");
   AST_DONE_ACK:
      assert property (param_read_rsp_i.ack && !param_read_req_o.eeprom |=>
         ram_read_done_o) else $error("done missing");
   AST_DW_FLAG:
      assert property (param_read_rsp_i.ack && param_read_rsp_i.double_word &&
         !param_read_rsp_i.error |=> double_word_read_flag_o)
         else $error("two-word flag missing");
   AST_STATUS:
      assert property (prog_idx_i == IDX_DRV_STATUS |=>
         prog_rdata_o == $past(drive_status_i)) else $error("status stale");
endmodule // drive_ctrl_asserts

bind drive_control_special_registers drive_ctrl_asserts u_chk (.mclk_i,
   .srst_i, .prog_wr_i, .prog_idx_i, .prog_wdata_i, .prog_rdata_o,
   .terminal_inputs_i, .run_command_o, .drive_status_i,
   .program_function_enable_i, .user_fault_alarm_o, .user_fault_code_o,
   .core_mode_error_i, .core_param_error_i, .core_param_number_i,
   .ram_read_command_i, .ram_read_done_o, .double_word_read_flag_o,
   .param_read_req_o, .param_read_rsp_i);

// ### tb/tb_top.sv
// self-checking bench for the drive control special registers
`timescale 1ns/1ps
module tb_top;
   import drive_ctrl_pkg::*;
   logic mclk_i = 1'h0, srst_i = 1'h1, prog_wr_i = 1'h0;
   logic [4:0] prog_idx_i = 5'h00;
   logic [15:0] prog_wdata_i = '0, prog_rdata_o, drive_status_i = '0;
   logic special_register_select_flag_i = 1'h0, sequence_start_input_i = 1'h0;
   logic [11:0] per_bit_control_flags_i = '0, terminal_inputs_i = '0;
   logic [11:0] fieldbus_inputs_i = '0, run_command_o;
   logic sequence_start_o, user_fault_clear_i = 1'h0, user_fault_alarm_o;
   logic [15:0] program_function_enable_i = '0, user_fault_code_o;
   logic core_mode_error_i = 1'h0, core_param_error_i = 1'h0;
   logic [15:0] core_param_number_i = '0;
   logic [7:0] monitor_select_params_i [PANEL_SLOTS] = '{8'h00, 8'h00, 8'h00};
   panel_view_t panel_view_o [PANEL_SLOTS];
   logic ram_read_command_i = 1'h0, eeprom_read_command_i = 1'h0;
   logic ram_read_done_o, eeprom_read_done_o, double_word_read_flag_o;
   param_read_req_t param_read_req_o;
   param_read_rsp_t param_read_rsp_i = '0;
   int fails = 0, checked = 0;
   drive_control_special_registers dut (.mclk_i, .srst_i, .prog_wr_i,
      .prog_idx_i, .prog_wdata_i, .prog_rdata_o,
      .special_register_select_flag_i, .per_bit_control_flags_i,
      .terminal_inputs_i, .fieldbus_inputs_i, .sequence_start_input_i,
      .run_command_o, .sequence_start_o, .drive_status_i,
      .program_function_enable_i, .user_fault_clear_i, .user_fault_alarm_o,
      .user_fault_code_o, .core_mode_error_i, .core_param_error_i,
      .core_param_number_i, .monitor_select_params_i, .panel_view_o,
      .ram_read_command_i, .eeprom_read_command_i, .ram_read_done_o,
      .eeprom_read_done_o, .double_word_read_flag_o, .param_read_req_o,
      .param_read_rsp_i);
   initial forever #2 mclk_i = ~mclk_i;
   task automatic close_out;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [4:0] i, input logic [15:0] d);
      @(negedge mclk_i);
      prog_idx_i = i;
      prog_wdata_i = d;
      prog_wr_i = 1'h1;
      @(negedge mclk_i);
      prog_wr_i = 1'h0;
   endtask
   task automatic rd(input logic [4:0] i, input logic [15:0] e);
      @(negedge mclk_i);
      prog_idx_i = i;
      @(negedge mclk_i);
      chk(prog_rdata_o, e);
   endtask
   task automatic wait2;
      repeat (2) @(negedge mclk_i);
   endtask
   task automatic t_mask;
      rd(IDX_CTRL_MASK, 16'h0000);
      terminal_inputs_i = 12'hFFF;
      per_bit_control_flags_i = 12'h100;
      special_register_select_flag_i = 1'h1;
      sequence_start_input_i = 1'h1;
      wr(IDX_OPER_CTRL, 16'h0005);
      wr(IDX_CTRL_MASK, 16'hFFFF);
      rd(IDX_CTRL_MASK, 16'h0FFF);
      chk(run_command_o, 12'h145);
      chk(sequence_start_o, 1'h1);
      special_register_select_flag_i = 1'h0;
      wait2;
      chk(run_command_o, 12'h040);
      terminal_inputs_i = 12'h000;
      fieldbus_inputs_i = 12'h0A0;
      wr(IDX_CTRL_MASK, 16'h0020);
      wait2;
      chk(run_command_o, 12'h080);
   endtask
   task automatic t_err;
      rd(IDX_ACC_ERR, 16'h0000);
      core_mode_error_i = 1'h1;
      @(negedge mclk_i);
      core_mode_error_i = 1'h0;
      rd(IDX_ACC_ERR, 16'hFFFF);
      wr(IDX_ACC_ERR, 16'h1234);
      rd(IDX_ACC_ERR, 16'hFFFF);
      wr(IDX_ACC_ERR, 16'h0000);
      rd(IDX_ACC_ERR, 16'h0000);
      core_param_number_i = 16'h000A;
      core_param_error_i = 1'h1;
      @(negedge mclk_i);
      core_param_error_i = 1'h0;
      rd(IDX_ACC_ERR, 16'h800A);
      wr(IDX_ACC_ERR, 16'h0000);
      drive_status_i = 16'hA5C3;
      wr(IDX_DRV_STATUS, 16'h0000);
      rd(IDX_DRV_STATUS, 16'hA5C3);
   endtask
   task automatic t_fault;
      wr(IDX_USER_FAULT, 16'h0010);
      chk(user_fault_alarm_o, 1'h0);
      program_function_enable_i = 16'h0001;
      wr(IDX_USER_FAULT, 16'h000F);
      chk(user_fault_alarm_o, 1'h0);
      wr(IDX_USER_FAULT, 16'h0015);
      chk(user_fault_alarm_o, 1'h0);
      for (int v = 16; v <= 20; v++) begin
         wr(IDX_USER_FAULT, 16'(v));
         chk(user_fault_alarm_o, 1'h1);
         chk(user_fault_code_o, 16'(v));
         user_fault_clear_i = 1'h1;
         @(negedge mclk_i);
         user_fault_clear_i = 1'h0;
      end
   endtask
   task automatic t_panel;
      wr(IDX_MON_ONE, 16'h1111);
      wr(IDX_MON_TWO, 16'h2222);
      wr(IDX_MON_THREE, 16'h3333);
      wr(IDX_MON_DEC, 16'hF9FF);
      monitor_select_params_i = '{8'h28, 8'h29, 8'h2A};
      wait2;
      chk(panel_view_o[0], {1'h1, 2'h1, 16'h1111});
      chk(panel_view_o[1], {1'h1, 2'h2, 16'h2222});
      chk(panel_view_o[2], {1'h1, 2'h3, 16'h3333});
      wr(IDX_MON_DEC, 16'hC0FF);
      monitor_select_params_i[0] = 8'h2B;
      wait2;
      chk(panel_view_o[0], 19'h00000);
      chk(panel_view_o[1], {1'h1, 2'h0, 16'h2222});
   endtask
   task automatic rdp(input logic ee, input logic [15:0] num, input logic
      [15:0] cal, input logic [31:0] d, input logic dw, input logic er);
      int n;
      wr(ee ? IDX_EEP_NUM : IDX_RAM_NUM, num);
      wr(ee ? IDX_EEP_CAL : IDX_RAM_CAL, cal);
      ram_read_command_i = !ee;
      eeprom_read_command_i = ee;
      n = 0;
      while (param_read_req_o.req !== 1'h1 && n < 20) begin
         @(negedge mclk_i);
         n++;
      end
      chk(param_read_req_o.req, 1'h1);
      chk(param_read_req_o[32:0], {ee, num, cal});
      @(negedge mclk_i);
      param_read_rsp_i = '{1'h1, er, dw, d};
      @(negedge mclk_i);
      param_read_rsp_i = '0;
      chk({ram_read_done_o, eeprom_read_done_o}, {!ee, ee});
      ram_read_command_i = 1'h0;
      eeprom_read_command_i = 1'h0;
      wait2;
      chk({ram_read_done_o, eeprom_read_done_o}, 2'h0);
   endtask
   task automatic t_read;
      rdp(1'h0, 16'h0386, 16'h0002, 32'h12345678, 1'h0, 1'h0);
      rd(IDX_RAM_CONT, 16'h5678);
      rdp(1'h1, 16'h0370, 16'h0000, 32'hCAFE8765, 1'h1, 1'h0);
      chk(double_word_read_flag_o, 1'h1);
      rd(IDX_EEP_DW_LO, 16'h8765);
      rd(IDX_EEP_DW_HI, 16'hCAFE);
      rdp(1'h0, 16'h0384, 16'h0001, 32'h00009999, 1'h0, 1'h1);
      rd(IDX_ACC_ERR, 16'h8384);
      rd(IDX_RAM_CONT, 16'h5678);
      rdp(1'h1, 16'h0001, 16'h0000, 32'h00000042, 1'h0, 1'h0);
      rd(IDX_ACC_ERR, 16'h8384);
      rd(IDX_EEP_CONT, 16'h0042);
   endtask
   initial begin
      repeat (3) @(negedge mclk_i);
      srst_i = 1'h0;
      t_mask;
      t_err;
      t_fault;
      t_panel;
      t_read;
      rd(5'h13, 16'h0000);
      close_out;
   end
   // the whole sequence takes about a hundred and thirty cycles
   initial begin
      repeat (4000) @(posedge mclk_i);
      fails++;
      close_out;
   end
endmodule // tb_top
